// ### ulp_map.vh
`ifndef ULP_MAP_VH
`define ULP_MAP_VH
// System clock 125 MHz, period in ps.
`define ULP_CLK_PERIOD_PS 8000
// Nominal 960 kHz output clock period in ps and half period in system cycles.
`define ULP_CLK960_PERIOD_PS 1041667
`define ULP_CLK960_HALF_CYC (`ULP_CLK960_PERIOD_PS / (2 * `ULP_CLK_PERIOD_PS))
// Divide ratio from the 960 kHz clock to the 120 kHz symbol clock.
`define ULP_TX_DIV 8
// Fractional divider increments for line-locked clocks: 7.68, 0.512, 0.768, 1.536 MHz.
// Phase accumulator is 24 bits; increment = f * 2^24 / 125 MHz.
`define ULP_INC_7680K 24'h0F_BA88
`define ULP_INC_512K 24'h01_0C6F
`define ULP_INC_768K 24'h01_92A7
`define ULP_INC_1536K 24'h03_254E
// Mode codes on the slot straps in continuous modes.
`define ULP_SLOT_PBX 3'h4
`define ULP_SLOT_TE 3'h5
// Ternary symbol codes on the two symbol bits.
`define ULP_SYM_ZERO 2'h0
`define ULP_SYM_PLUS 2'h2
`define ULP_SYM_MINUS 2'h3
`endif

// ### ulp_sync2.v
`timescale 1ns/10ps
// Two-stage synchroniser for a group of asynchronous inputs.
module ulp_sync2 #(
   parameter W = 1
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta;
   reg [W-1:0] stab;
   // The first stage feeds only the second stage.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= {W{1'b0}};
         stab <= {W{1'b0}};
      end else if (ce_i) begin
         meta <= d_i;
         stab <= meta;
      end
   end
   assign q_o = stab;
endmodule // ulp_sync2

// ### ulp_line_port.v
`timescale 1ns/10ps
`include "ulp_map.vh"
module ulp_line_port (
   input wire CLK_I,
   input wire RST_N_I,
   input wire CE_I,
   input wire LINE_TERM_STRAP_I,
   input wire BURST_STRAP_I,
   input wire SLOT_SELECT_BIT0_I,
   input wire SLOT_SELECT_BIT1_I,
   input wire SLOT_SELECT_BIT2_I,
   input wire SERIAL_FORMAT_STRAP_I,
   input wire SINGLE_CHIP_I,
   input wire POWERDOWN_REQ_I,
   input wire RANGE_REQ_I,
   input wire LOOP_REQ_I,
   input wire [1:0] TX_SYMBOL_I,
   output wire TX_SYMBOL_READY_O,
   input wire ANALOG_MASTER_CLK_I,
   input wire ADC_STREAM_I,
   input wire LINE_LEVEL_I,
   input wire LINE_LOCK_STROBE_I,
   input wire PORT_CLK_I,
   input wire PORT_FRAME_I,
   input wire PORT_DATA_IN_I,
   input wire PORT_TX_BIT_I,
   input wire MULTI_PURPOSE_CLOCK_PIN_I,
   output reg MULTI_PURPOSE_CLOCK_PIN_O,
   output wire MULTI_PURPOSE_CLOCK_PIN_OE_O,
   output reg POWER_FEED_OFF_O,
   output reg ANALOG_POWERDOWN_CTRL_O,
   output reg RANGE_CTRL_O,
   output reg LOOP_CTRL_O,
   output reg CLK_960K_OUT_O,
   output reg TX_SYMBOL_CLK_O,
   output reg TERNARY_SYM_BIT0_O,
   output reg TERNARY_SYM_BIT1_O,
   output reg TEST_MODE_PIN_ZERO_O,
   output reg ADC_SAMPLE_O,
   output reg ADC_SAMPLE_VALID_O,
   output reg WAKE_O,
   output reg PORT_RX_BIT_O,
   output reg PORT_RX_VALID_O,
   output reg PORT_FRAME_START_O,
   output reg PORT_DATA_OUT_O,
   output reg [2:0] TIME_SLOT_O,
   output reg [3:0] MODE_O
);
   // Mode one-hot codes reported on MODE_O.
   localparam MODE_LINE = 4'b0001;
   localparam MODE_NET = 4'b0010;
   localparam MODE_PBX = 4'b0100;
   localparam MODE_TE = 4'b1000;

   // All asynchronous pins except PORT_TX_BIT_I pass two flip-flops before use.
   wire [10:0] sync_raw;
   wire [10:0] sync_q;
   assign sync_raw = {LINE_TERM_STRAP_I, BURST_STRAP_I, SLOT_SELECT_BIT2_I, SLOT_SELECT_BIT1_I,
      SLOT_SELECT_BIT0_I, SERIAL_FORMAT_STRAP_I, ANALOG_MASTER_CLK_I, ADC_STREAM_I,
      LINE_LEVEL_I, PORT_CLK_I, MULTI_PURPOSE_CLOCK_PIN_I};
   ulp_sync2 #(
      .W(11)
   ) u_sync (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .d_i(sync_raw),
      .q_o(sync_q)
   );
   // Frame and data pins are sampled on port clock edges, so a separate pair suffices.
   wire [1:0] port_q;
   ulp_sync2 #(
      .W(2)
   ) u_sync_port (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .d_i({PORT_FRAME_I, PORT_DATA_IN_I}),
      .q_o(port_q)
   );
   wire s_lt = sync_q[10];
   wire s_burst = sync_q[9];
   wire [2:0] s_slot = sync_q[8:6];
   wire s_fmt2 = sync_q[5];
   wire s_mclk = sync_q[4];
   wire s_adc = sync_q[3];
   wire s_level = sync_q[2];
   wire s_pclk = sync_q[1];
   wire s_cls = sync_q[0];

   // Mode decode from the straps.
   reg [3:0] next_mode;
   always @* begin
      next_mode = MODE_NET;
      if (s_lt) begin
         next_mode = MODE_LINE;
      end else if (s_burst) begin
         next_mode = MODE_PBX;
      end else if (s_slot == `ULP_SLOT_PBX) begin
         next_mode = MODE_PBX;
      end else if (s_slot == `ULP_SLOT_TE) begin
         next_mode = MODE_TE;
      end
   end
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         MODE_O <= MODE_NET;
         TIME_SLOT_O <= 3'h0;
      end else if (CE_I) begin
         MODE_O <= next_mode;
         TIME_SLOT_O <= s_burst ? s_slot : 3'h0;
      end
   end

   // Analog control outputs are registered copies of the requests.
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ANALOG_POWERDOWN_CTRL_O <= 1'b1;
         RANGE_CTRL_O <= 1'b0;
         LOOP_CTRL_O <= 1'b0;
      end else if (CE_I) begin
         ANALOG_POWERDOWN_CTRL_O <= POWERDOWN_REQ_I;
         RANGE_CTRL_O <= RANGE_REQ_I;
         LOOP_CTRL_O <= LOOP_REQ_I;
      end
   end

   // 960 kHz divider and divide-by-8 symbol clock; the symbol clock toggles on
   // every eighth 960 kHz edge, four whole periods, so it is one eighth of that rate.
   localparam integer HALF960_INT = `ULP_CLK960_HALF_CYC - 1;
   localparam [9:0] HALF960 = HALF960_INT[9:0];
   localparam integer TX_LAST_INT = `ULP_TX_DIV - 1;
   localparam [2:0] TX_LAST = TX_LAST_INT[2:0];
   reg [9:0] div_cnt;
   reg [2:0] tx_cnt;
   wire half_tick = (div_cnt == HALF960);
   wire tx_toggle = half_tick && (tx_cnt == TX_LAST);
   wire tx_rise = tx_toggle && !TX_SYMBOL_CLK_O;
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         div_cnt <= 10'h000;
         tx_cnt <= 3'h0;
         CLK_960K_OUT_O <= 1'b0;
         TX_SYMBOL_CLK_O <= 1'b0;
      end else if (CE_I) begin
         if (half_tick) begin
            div_cnt <= 10'h000;
            CLK_960K_OUT_O <= ~CLK_960K_OUT_O;
            tx_cnt <= tx_cnt + 3'h1;
            if (tx_toggle) begin
               TX_SYMBOL_CLK_O <= ~TX_SYMBOL_CLK_O;
            end
         end else begin
            div_cnt <= div_cnt + 10'h001;
         end
      end
   end
   // A frozen block takes no symbol, so ready is held off while the enable is low.
   assign TX_SYMBOL_READY_O = tx_rise & CE_I;

   // Symbol bits change together with the rising symbol clock; the illegal
   // code is mapped to zero so it can never appear on the pins.
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         TERNARY_SYM_BIT0_O <= 1'b0;
         TERNARY_SYM_BIT1_O <= 1'b0;
         TEST_MODE_PIN_ZERO_O <= 1'b0;
      end else if (CE_I) begin
         TEST_MODE_PIN_ZERO_O <= SINGLE_CHIP_I & ~TX_SYMBOL_CLK_O & tx_rise | SINGLE_CHIP_I &
            TX_SYMBOL_CLK_O & ~tx_toggle;
         if (tx_rise) begin
            if (TX_SYMBOL_I == 2'b01) begin
               TERNARY_SYM_BIT0_O <= 1'b0;
               TERNARY_SYM_BIT1_O <= 1'b0;
            end else begin
               TERNARY_SYM_BIT0_O <= TX_SYMBOL_I[0];
               TERNARY_SYM_BIT1_O <= TX_SYMBOL_I[1];
            end
         end
      end
   end

   // ADC stream taken on rising master-clock edges, and wake on a polarity change.
   reg mclk_d;
   reg level_d;
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mclk_d <= 1'b0;
         level_d <= 1'b0;
         ADC_SAMPLE_O <= 1'b0;
         ADC_SAMPLE_VALID_O <= 1'b0;
         WAKE_O <= 1'b0;
      end else if (CE_I) begin
         mclk_d <= s_mclk;
         level_d <= s_level;
         ADC_SAMPLE_VALID_O <= s_mclk & ~mclk_d;
         if (s_mclk & ~mclk_d) begin
            ADC_SAMPLE_O <= s_adc;
         end
         // Wake holds until the analog chip leaves power-down.
         if (!ANALOG_POWERDOWN_CTRL_O) begin
            WAKE_O <= 1'b0;
         end else if (s_level != level_d) begin
            WAKE_O <= 1'b1;
         end
      end
   end

   // Serial port: port clock is twice the bit rate; data is taken on every second
   // rising edge and driven on the falling edge after it, frame restarts the bit phase.
   reg pclk_d;
   reg bit_phase;
   wire pclk_rise = s_pclk & ~pclk_d;
   wire pclk_fall = ~s_pclk & pclk_d;
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pclk_d <= 1'b0;
         bit_phase <= 1'b0;
         PORT_RX_BIT_O <= 1'b0;
         PORT_RX_VALID_O <= 1'b0;
         PORT_FRAME_START_O <= 1'b0;
         PORT_DATA_OUT_O <= 1'b1;
      end else if (CE_I) begin
         pclk_d <= s_pclk;
         PORT_RX_VALID_O <= 1'b0;
         PORT_FRAME_START_O <= 1'b0;
         if (pclk_rise) begin
            if (port_q[1]) begin
               // The frame edge carries a bit, so the next rising edge is the idle one.
               bit_phase <= 1'b0;
               PORT_FRAME_START_O <= 1'b1;
            end else begin
               bit_phase <= ~bit_phase;
            end
            if (bit_phase || port_q[1]) begin
               PORT_RX_BIT_O <= port_q[0];
               PORT_RX_VALID_O <= 1'b1;
            end
         end
         if (pclk_fall && !bit_phase) begin
            PORT_DATA_OUT_O <= PORT_TX_BIT_I;
         end
      end
   end

   // Line-locked clock on the multi-purpose pin: a phase accumulator whose
   // phase is realigned by the line-lock strobe from the receiver. Jitter is
   // one system cycle, the price of deriving all rates from one clock.
   reg [23:0] phase;
   reg [23:0] inc;
   always @* begin
      case (MODE_O)
         MODE_NET: inc = `ULP_INC_7680K;
         MODE_PBX: inc = `ULP_INC_512K;
         MODE_TE: inc = s_fmt2 ? `ULP_INC_768K : `ULP_INC_1536K;
         default: inc = 24'h00_0000;
      endcase
   end
   assign MULTI_PURPOSE_CLOCK_PIN_OE_O = (MODE_O != MODE_LINE);
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         phase <= 24'h00_0000;
         MULTI_PURPOSE_CLOCK_PIN_O <= 1'b0;
         POWER_FEED_OFF_O <= 1'b0;
      end else if (CE_I) begin
         phase <= LINE_LOCK_STROBE_I ? 24'h00_0000 : phase + inc;
         MULTI_PURPOSE_CLOCK_PIN_O <= (MODE_O != MODE_LINE) & phase[23];
         POWER_FEED_OFF_O <= (MODE_O == MODE_LINE) & s_cls;
      end
   end
endmodule // ulp_line_port

// ### ulp_line_port_sva.sv
`timescale 1ns/10ps
// Port checks of the line port; a single clock domain, so clocking is shared.
module ulp_line_port_sva (
   input logic CLK_I,
   input logic RST_N_I,
   input logic CE_I,
   input logic POWERDOWN_REQ_I,
   input logic RANGE_REQ_I,
   input logic LOOP_REQ_I,
   input logic TX_SYMBOL_READY_O,
   input logic MULTI_PURPOSE_CLOCK_PIN_OE_O,
   input logic ANALOG_POWERDOWN_CTRL_O,
   input logic RANGE_CTRL_O,
   input logic LOOP_CTRL_O,
   input logic CLK_960K_OUT_O,
   input logic TX_SYMBOL_CLK_O,
   input logic TERNARY_SYM_BIT0_O,
   input logic TERNARY_SYM_BIT1_O,
   input logic [3:0] MODE_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   reg ok, p960, ptx, hv, tv;
   reg [9:0] hc, tc;
   wire c960 = CLK_960K_OUT_O != p960;
   wire ctx = TX_SYMBOL_CLK_O != ptx;
   // Half-period counters; the first toggle after reset only arms them, as its phase is free.
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         {ok, p960, ptx, hv, tv} <= 5'h00;
         {hc, tc} <= 20'h0_0000;
      end else begin
         ok <= CE_I;
         if (CE_I) begin
            {p960, ptx} <= {CLK_960K_OUT_O, TX_SYMBOL_CLK_O};
            {hv, tv} <= {hv | c960, tv | ctx};
            hc <= c960 ? 10'h000 : hc + 10'h001;
            tc <= ctx ? 10'h000 : tc + 10'h001;
         end
      end
   end
   pd_ctrl_a: assert property (ok |->
      ANALOG_POWERDOWN_CTRL_O == $past(POWERDOWN_REQ_I)) else $error("power-down lag");
   range_ctrl_a: assert property (ok |-> RANGE_CTRL_O == $past(RANGE_REQ_I))
      else $error("range lag");
   loop_ctrl_a: assert property (ok |-> LOOP_CTRL_O == $past(LOOP_REQ_I))
      else $error("loop lag");
   clk_half_a: assert property (c960 && hv && CE_I |-> hc == 10'd64)
      else $error("960k half period");
   tx_div_a: assert property (ctx && tv && CE_I |-> tc == 10'd519)
      else $error("tx clock divide");
   sym_code_a: assert property (!(TERNARY_SYM_BIT0_O && !TERNARY_SYM_BIT1_O))
      else $error("unused symbol code");
   sym_edge_a: assert property ($changed({TERNARY_SYM_BIT1_O, TERNARY_SYM_BIT0_O}) |->
      $rose(TX_SYMBOL_CLK_O)) else $error("symbol off edge");
   ready_rise_a: assert property (TX_SYMBOL_READY_O && CE_I |=> $rose(TX_SYMBOL_CLK_O))
      else $error("take without tx edge");
   pin_dir_a: assert property (MULTI_PURPOSE_CLOCK_PIN_OE_O == (MODE_O != 4'h1))
      else $error("pin direction");
   cover property (TX_SYMBOL_READY_O);
   cover property (MODE_O == 4'h8);
   cover property (ok && $rose(LOOP_CTRL_O));
endmodule // ulp_line_port_sva
bind ulp_line_port ulp_line_port_sva chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
   .POWERDOWN_REQ_I(POWERDOWN_REQ_I), .RANGE_REQ_I(RANGE_REQ_I), .LOOP_REQ_I(LOOP_REQ_I),
   .TX_SYMBOL_READY_O(TX_SYMBOL_READY_O), .MODE_O(MODE_O),
   .MULTI_PURPOSE_CLOCK_PIN_OE_O(MULTI_PURPOSE_CLOCK_PIN_OE_O),
   .ANALOG_POWERDOWN_CTRL_O(ANALOG_POWERDOWN_CTRL_O), .RANGE_CTRL_O(RANGE_CTRL_O),
   .LOOP_CTRL_O(LOOP_CTRL_O), .CLK_960K_OUT_O(CLK_960K_OUT_O), .TX_SYMBOL_CLK_O(TX_SYMBOL_CLK_O),
   .TERNARY_SYM_BIT0_O(TERNARY_SYM_BIT0_O), .TERNARY_SYM_BIT1_O(TERNARY_SYM_BIT1_O));

// ### ulp_afe_model.sv
`timescale 1ns/10ps
// Behavioural analog front end facing the line port.
module ulp_afe_model (
   input wire pd_i,
   input wire bit_i,
   input wire pol_i,
   output reg mclk_o,
   output reg adc_o,
   output wire level_o
);
   // The oscillator keeps running in power-down, so the master clock never stops.
   initial begin
      adc_o = 1'b0;
      mclk_o = 1'b0;
      forever #32.55 mclk_o = ~mclk_o;
   end
   // Stream moves 24 ns after the clock rises; a powered-down converter gives only junk.
   always @(posedge mclk_o) begin
      adc_o <= #24 pd_i ? ~adc_o : bit_i;
   end
   assign level_o = pol_i;
endmodule // ulp_afe_model

// ### tb.sv
`timescale 1ns/10ps
// Self-checking bench for the line port.
module tb;
   reg clk = 1'b0, rst_n = 1'b0, ce = 1'b1, lt = 1'b0, burst = 1'b0, fmt = 1'b0;
   reg single = 1'b0, adc_bit = 1'b0, pol = 1'b0, feed = 1'b0, p;
   reg q, strobe = 1'b0, pclk = 1'b0, pfr = 1'b0, pdin = 1'b0, ptx = 1'b0;
   reg [7:0] pat = 8'hA5;
   reg [2:0] slot = 3'h0, req = 3'h4;
   reg [1:0] sym = 2'h0;
   reg [23:0] rows [0:8];
   wire mclk, adc, lvl, rdy, pin_o, oe, pfo, pd_o, rg_o, lp_o, txc, b0, b1, tm0, smp, smpv, wake;
   wire c960, rxb, rxv, fst, pout;
   wire [2:0] ts;
   wire [3:0] mode;
   wire pin = oe ? pin_o : feed;
   integer num_errors = 0, checks_done = 0, cyc = 0, i, k, n, m;
   ulp_line_port dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .LINE_TERM_STRAP_I(lt),
      .BURST_STRAP_I(burst), .SLOT_SELECT_BIT0_I(slot[0]), .SLOT_SELECT_BIT1_I(slot[1]),
      .SLOT_SELECT_BIT2_I(slot[2]), .SERIAL_FORMAT_STRAP_I(fmt), .SINGLE_CHIP_I(single),
      .POWERDOWN_REQ_I(req[2]), .RANGE_REQ_I(req[1]), .LOOP_REQ_I(req[0]), .TX_SYMBOL_I(sym),
      .TX_SYMBOL_READY_O(rdy), .ANALOG_MASTER_CLK_I(mclk), .ADC_STREAM_I(adc),
      .LINE_LEVEL_I(lvl), .LINE_LOCK_STROBE_I(strobe), .PORT_CLK_I(pclk), .PORT_FRAME_I(pfr),
      .PORT_DATA_IN_I(pdin), .PORT_TX_BIT_I(ptx), .MULTI_PURPOSE_CLOCK_PIN_I(pin),
      .MULTI_PURPOSE_CLOCK_PIN_O(pin_o), .MULTI_PURPOSE_CLOCK_PIN_OE_O(oe),
      .POWER_FEED_OFF_O(pfo), .ANALOG_POWERDOWN_CTRL_O(pd_o), .RANGE_CTRL_O(rg_o),
      .LOOP_CTRL_O(lp_o), .CLK_960K_OUT_O(c960), .TX_SYMBOL_CLK_O(txc), .TERNARY_SYM_BIT0_O(b0),
      .TERNARY_SYM_BIT1_O(b1), .TEST_MODE_PIN_ZERO_O(tm0), .ADC_SAMPLE_O(smp),
      .ADC_SAMPLE_VALID_O(smpv), .WAKE_O(wake), .PORT_RX_BIT_O(rxb), .PORT_RX_VALID_O(rxv),
      .PORT_FRAME_START_O(fst), .PORT_DATA_OUT_O(pout), .TIME_SLOT_O(ts), .MODE_O(mode));
   ulp_afe_model afe (.pd_i(pd_o), .bit_i(adc_bit), .pol_i(pol), .mclk_o(mclk), .adc_o(adc),
      .level_o(lvl));
   initial forever #4 clk = ~clk;
   task give_verdict;
      begin
         if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // Runaway guard: the whole plan takes about 20000 cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors = num_errors + 1;
         give_verdict;
      end
   end
   // Rows: lt, burst, slot, format, requests, mode, time slot, pin edges in 2000 cycles.
   initial begin
      rows[0] = 24'h80_8800; rows[1] = 24'h8D_0800; rows[2] = 24'hEA_0D00;
      rows[3] = 24'h05_907B; rows[4] = 24'h0A_907B; rows[5] = 24'h27_2008;
      rows[6] = 24'h2F_C00C; rows[7] = 24'h28_4019; rows[8] = 24'h5D_2308;
      repeat (3) @(negedge clk);
      chk("reset", {pd_o, oe, mode}, 8'h32);
      rst_n = 1'b1;
      for (i = 0; i < 9; i = i + 1) begin
         {lt, burst, slot, fmt, req} = rows[i][23:15];
         feed = rows[i][15];
         repeat (20) @(negedge clk);
         chk("mode", mode, rows[i][14:11]);
         chk("slot", ts, rows[i][10:8]);
         chk("ctrl", {pd_o, rg_o, lp_o}, req);
         chk("oe", oe, !lt);
         if (lt) chk("feed", pfo, feed);
         else begin
            n = 0;
            repeat (2000) begin
               p = pin_o;
               @(negedge clk);
               n = n + (pin_o & ~p);
            end
            chk("edges", (n + 1 >= rows[i][7:0] && n <= rows[i][7:0] + 1) ? rows[i][7:0] : n,
               rows[i][7:0]);
         end
      end
      // The strobe restarts the line clock phase, so the pin rises about 124 cycles later.
      strobe = 1'b1;
      @(negedge clk);
      strobe = 1'b0;
      repeat (100) @(negedge clk);
      chk("lock low", pin_o, 1'b0);
      repeat (50) @(negedge clk);
      chk("lock high", pin_o, 1'b1);
      // Two symbol periods span exactly sixteen 960 kHz periods.
      n = 0;
      m = 0;
      repeat (2080) begin
         p = c960;
         q = txc;
         @(negedge clk);
         n = n + (c960 & ~p);
         m = m + (txc & ~q);
      end
      chk("960k", n, 16);
      chk("tx rate", m, 2);
      // Port clock of 16 cycles: frame on the first rise, a bit every second rise,
      // and the out bit loaded on the fall in between.
      n = 0;
      m = 0;
      for (k = 0; k < 32; k = k + 1) begin
         {pclk, pfr, pdin, ptx} = {k[0], k < 2, pat[k / 4], !pat[k / 4]};
         repeat (8) begin
            @(negedge clk);
            if (rxv === 1'b1) chk("rx bit", rxb, pat[k / 4]);
            n = n + rxv;
            m = m + fst;
         end
         if (k % 4 == 3) chk("tx bit", pout, !pat[k / 4]);
      end
      pclk = 1'b0;
      chk("rx count", n, 8);
      chk("frame", m, 1);
      for (k = 0; k < 4; k = k + 1) begin
         sym = {k[0], k[1]};
         n = 0;
         while (rdy !== 1'b1 && n < 1100) begin
            @(negedge clk);
            n = n + 1;
         end
         chk("ready", rdy, 1'b1);
         @(negedge clk);
         chk("sym", {b1, b0}, (sym == 2'h1) ? 2'h0 : sym);
         chk("txclk", txc, 1'b1);
      end
      single = 1'b1;
      @(negedge clk);
      repeat (1100) begin
         @(negedge clk);
         chk("tm0", tm0, txc);
      end
      for (k = 0; k < 2; k = k + 1) begin
         adc_bit = k[0];
         repeat (60) @(negedge clk);
         n = 0;
         while (smpv !== 1'b1 && n < 40) begin
            @(negedge clk);
            n = n + 1;
         end
         chk("adc", smp, adc_bit);
      end
      req = 3'h4;
      repeat (20) @(negedge clk);
      pol = 1'b1;
      repeat (20) @(negedge clk);
      chk("wake", wake, 1'b1);
      req = 3'h0;
      repeat (20) @(negedge clk);
      chk("wake", wake, 1'b0);
      // A reset in mid-run brings back the start-up values at once.
      rst_n = 1'b0;
      @(negedge clk);
      chk("reset", {pd_o, oe, mode}, 8'h32);
      chk("reset sym", {b1, b0, txc, wake}, 4'h0);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      ce = 1'b0;
      req = 3'h7;
      repeat (5) @(negedge clk);
      chk("freeze", {pd_o, rg_o, lp_o}, 3'h0);
      ce = 1'b1;
      give_verdict;
   end
endmodule // tb
